//--- inc/cmmc_consts.svh
// constants for the can module mode control block
`ifndef CMMC_CONSTS_SVH
`define CMMC_CONSTS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define CMMC_ADDR_W 4
`define CMMC_CTRL_OFS 4'h0

// ----------------------------------------------------------------
// field positions of can_module_control
// ----------------------------------------------------------------
`define CMMC_ABORT_BIT 27
`define CMMC_REQUESTED_OP_MODE_LSB 24
`define CMMC_CURRENT_OP_MODE_LSB 21
`define CMMC_CAP_BIT 20
`define CMMC_ON_BIT 15
`define CMMC_SIDLE_BIT 13
`define CMMC_BUSY_BIT 11
`define CMMC_DNCNT_LSB 0

// ----------------------------------------------------------------
// mode codes and reset values
// ----------------------------------------------------------------
`define CMMC_MODE_NORMAL 3'h0
`define CMMC_MODE_DISABLE 3'h1
`define CMMC_MODE_LOOPBACK 3'h2
`define CMMC_MODE_LISTEN_ONLY 3'h3
`define CMMC_MODE_CONFIG 3'h4
`define CMMC_MODE_LISTEN_ALL 3'h7
`define CMMC_RST_MODE 3'h4

// ----------------------------------------------------------------
// time stamp store
// ----------------------------------------------------------------
`define CMMC_TS_W 16
`define CMMC_TS_DEPTH 4
`define CMMC_TS_IDX_W 2

// axi response codes
`define CMMC_RESP_OKAY 2'h0
`define CMMC_RESP_SLVERR 2'h2

`endif

//--- inc/cmmc_pkg.sv
// types shared by the can module mode control block
package cmmc_pkg;
   typedef logic [2:0] cmmc_mode_t;
   typedef enum logic [1:0] {
      RUN_OFF,
      RUN_ON,
      RUN_DRAIN
   } cmmc_run_e;
endpackage

//--- src/cmmc_ts_mem.sv
// small time stamp store with registered read data
`timescale 1ns/1ps
`include "cmmc_consts.svh"
module cmmc_ts_mem
   import cmmc_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic wr_en_i,
   input wire logic [`CMMC_TS_IDX_W-1:0] wr_idx_i,
   input wire logic [`CMMC_TS_W-1:0] wr_data_i,
   input wire logic [`CMMC_TS_IDX_W-1:0] rd_idx_i,
   output logic [`CMMC_TS_W-1:0] rd_data_o
);
   logic [`CMMC_TS_W-1:0] mem_reg [`CMMC_TS_DEPTH];

   // ----------------------------------------------------------------
   // storage and read port
   // ----------------------------------------------------------------
   // write side, one entry per receive buffer
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < `CMMC_TS_DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else if (ce_i && wr_en_i) begin
         mem_reg[wr_idx_i] <= wr_data_i;
      end
   end

   // read data from a register, one cycle after the index
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_data_o <= '0;
      end else if (ce_i) begin
         rd_data_o <= mem_reg[rd_idx_i];
      end
   end
endmodule

//--- src/cmmc_top.sv
// can module mode control: control register, mode handover, abort and time stamps
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "cmmc_consts.svh"
module cmmc_top
   import cmmc_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // axi4-lite slave
   input wire logic [`CMMC_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [`CMMC_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // can core side
   input wire logic bus_active_i,
   input wire logic tx_pending_i,
   input wire logic rx_valid_i,
   input wire logic [`CMMC_TS_IDX_W-1:0] rx_buf_idx_i,
   input wire logic [`CMMC_TS_IDX_W-1:0] ts_rd_idx_i,
   output logic [`CMMC_TS_W-1:0] ts_rd_data_o,
   output logic [`CMMC_TS_W-1:0] timer_o,
   output logic tx_abort_o,
   output logic core_enable_o,
   output logic [2:0] mode_o
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic abort_reg;
   cmmc_mode_t requested_op_mode_reg;
   cmmc_mode_t current_op_mode_reg;
   logic cap_reg;
   logic on_reg;
   logic sidle_reg;
   logic [4:0] dncnt_reg;
   cmmc_run_e run_reg;
   logic [`CMMC_TS_W-1:0] timer_reg;
   logic aw_have_reg;
   logic w_have_reg;
   logic [`CMMC_ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic busy;
   logic wr_do;
   logic wr_hit;
   logic rd_hit;
   logic [31:0] ctrl_rd;

   // reserved codes 101 and 110 are never entered
   function automatic logic mode_legal(input cmmc_mode_t code);
      mode_legal = (code != 3'h5) && (code != 3'h6);
   endfunction

   function automatic logic addr_hit(input logic [`CMMC_ADDR_W-1:0] a);
      addr_hit = (a == `CMMC_CTRL_OFS);
   endfunction

   // ----------------------------------------------------------------
   // axi4-lite handshakes
   // ----------------------------------------------------------------
   // address and data taken in either order, response after both
   assign s_axi_awready_o = ce_i && !aw_have_reg && !s_axi_bvalid_o;
   assign s_axi_wready_o = ce_i && !w_have_reg && !s_axi_bvalid_o;
   assign s_axi_arready_o = ce_i && !s_axi_rvalid_o;
   assign wr_do = ce_i && aw_have_reg && w_have_reg;
   assign wr_hit = wr_do && addr_hit(awaddr_reg);
   assign rd_hit = addr_hit(s_axi_araddr_i);

   // write channel capture and response
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `CMMC_RESP_OKAY;
      end else if (ce_i) begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_reg <= 1'b1;
            wdata_reg <= s_axi_wdata_i;
            wstrb_reg <= s_axi_wstrb_i;
         end
         if (wr_do) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= addr_hit(awaddr_reg) ? `CMMC_RESP_OKAY : `CMMC_RESP_SLVERR;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // unimplemented bits are tied to zero in the read image
   assign ctrl_rd = {4'h0, abort_reg, requested_op_mode_reg, current_op_mode_reg, cap_reg, 4'h0,
                     on_reg, 1'b0, sidle_reg, 1'b0, busy, 6'h00, dncnt_reg};

   // read channel, data held in a register until taken
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= '0;
         s_axi_rresp_o <= `CMMC_RESP_OKAY;
      end else if (ce_i) begin
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_hit ? ctrl_rd : 32'h0000_0000;
            s_axi_rresp_o <= rd_hit ? `CMMC_RESP_OKAY : `CMMC_RESP_SLVERR;
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // control fields written by software
   // ----------------------------------------------------------------
   // plain read/write fields, byte lanes honoured
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         requested_op_mode_reg <= `CMMC_RST_MODE;
         cap_reg <= 1'b0;
         on_reg <= 1'b0;
         sidle_reg <= 1'b0;
         dncnt_reg <= '0;
      end else if (wr_hit) begin
         if (wstrb_reg[3]) begin
            requested_op_mode_reg <= wdata_reg[`CMMC_REQUESTED_OP_MODE_LSB +: 3];
         end
         if (wstrb_reg[2]) begin
            cap_reg <= wdata_reg[`CMMC_CAP_BIT];
         end
         if (wstrb_reg[1]) begin
            on_reg <= wdata_reg[`CMMC_ON_BIT];
            sidle_reg <= wdata_reg[`CMMC_SIDLE_BIT];
         end
         if (wstrb_reg[0]) begin
            dncnt_reg <= wdata_reg[`CMMC_DNCNT_LSB +: 5];
         end
      end
   end

   // abort: a write of one sets, zero is ignored; the set wins over the clear
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         abort_reg <= 1'b0;
      end else if (ce_i) begin
         if (wr_hit && wstrb_reg[3] && wdata_reg[`CMMC_ABORT_BIT]) begin
            abort_reg <= 1'b1;
         end else if (abort_reg && !tx_pending_i) begin
            abort_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // enable and mode handover
   // ----------------------------------------------------------------
   // a disable request drains the frame on the wire before shutting down
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         run_reg <= RUN_OFF;
      end else if (ce_i) begin
         unique case (run_reg)
            RUN_OFF: begin
               if (on_reg) begin
                  run_reg <= RUN_ON;
               end
            end
            RUN_ON: begin
               if (!on_reg) begin
                  run_reg <= bus_active_i ? RUN_DRAIN : RUN_OFF;
               end
            end
            RUN_DRAIN: begin
               if (!bus_active_i) begin
                  run_reg <= on_reg ? RUN_ON : RUN_OFF;
               end
            end
         endcase
      end
   end

   // busy stays high until the disable has really taken effect
   assign busy = (run_reg != RUN_OFF);
   assign core_enable_o = busy;
   assign tx_abort_o = abort_reg;
   assign mode_o = current_op_mode_reg;

   // mode follows the request only between frames, so no frame is cut
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         current_op_mode_reg <= `CMMC_RST_MODE;
      end else if (ce_i && run_reg == RUN_ON && !bus_active_i && mode_legal(requested_op_mode_reg)) begin
         current_op_mode_reg <= requested_op_mode_reg;
      end
   end

   // ----------------------------------------------------------------
   // time stamp timer and capture
   // ----------------------------------------------------------------
   // timer stops when capture is off, which saves its toggling power
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         timer_reg <= '0;
      end else if (ce_i && cap_reg && busy) begin
         timer_reg <= timer_reg + 16'h0001;
      end
   end
   assign timer_o = timer_reg;

   cmmc_ts_mem u_ts_mem (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .wr_en_i(rx_valid_i && cap_reg && busy),
      .wr_idx_i(rx_buf_idx_i),
      .wr_data_i(timer_reg),
      .rd_idx_i(ts_rd_idx_i),
      .rd_data_o(ts_rd_data_o)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   abort_set_a: assert property (
      wr_hit && wstrb_reg[3] && wdata_reg[`CMMC_ABORT_BIT] |=> abort_reg)
      else $error("abort write did not set the flag");
   abort_clear_a: assert property (
      ce_i && abort_reg && !tx_pending_i && !wr_hit |=> !abort_reg)
      else $error("abort flag not cleared after pending work ended");
   abort_hold_a: assert property (
      ce_i && abort_reg && tx_pending_i |=> abort_reg)
      else $error("abort flag dropped while transmission pending");
   mode_legal_a: assert property (
      mode_legal(current_op_mode_reg))
      else $error("current mode holds a reserved code");
   mode_wait_a: assert property (
      bus_active_i && !$past(sys_rst_i) |=> $stable(current_op_mode_reg))
      else $error("mode changed during a frame");
   mode_follow_a: assert property (
      ce_i && run_reg == RUN_ON && !bus_active_i && mode_legal(requested_op_mode_reg)
      |=> current_op_mode_reg == $past(requested_op_mode_reg))
      else $error("mode did not follow the request at idle");
   drain_busy_a: assert property (
      ce_i && run_reg == RUN_ON && !on_reg && bus_active_i |=> busy)
      else $error("busy dropped before the frame ended");
   off_a: assert property (
      !on_reg && !bus_active_i && ce_i |=> ##[0:1] !core_enable_o)
      else $error("module still enabled after disable");
   timer_stop_a: assert property (
      !cap_reg |=> $stable(timer_reg))
      else $error("timer ran with capture off");
   read_zero_a: assert property (
      s_axi_rvalid_o |-> s_axi_rdata_o[31:28] == 4'h0 && s_axi_rdata_o[19:16] == 4'h0
      && !s_axi_rdata_o[14])
      else $error("unimplemented bits read as one");

   cov_abort_c: cover property (abort_reg ##1 !abort_reg);
   cov_drain_c: cover property (run_reg == RUN_DRAIN ##[1:20] run_reg == RUN_OFF);
   cov_mode_c: cover property ($changed(current_op_mode_reg));
   cov_cap_c: cover property (rx_valid_i && cap_reg && busy);
endmodule

//--- sim/cmmc_can_peer.sv
// behavioural model of the can core and bus traffic around the control block
`timescale 1ns/1ps
`include "cmmc_consts.svh"
module cmmc_can_peer #(
   parameter int ABORT_LAT = 8
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic go_i,
   input wire logic [7:0] len_i,
   input wire logic pend_i,
   input wire logic abort_i,
   input wire logic [`CMMC_TS_IDX_W-1:0] idx_i,
   output logic bus_active_o,
   output logic tx_pending_o,
   output logic rx_valid_o,
   output logic [`CMMC_TS_IDX_W-1:0] rx_idx_o
);
   logic [7:0] left_reg;
   logic [7:0] drop_reg;
   // ----------------------------------------------------------------
   // frame on the bus; a valid message lands in the cycle after its last cycle
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         left_reg <= 8'h00;
         rx_valid_o <= 1'b0;
         rx_idx_o <= '0;
      end else begin
         left_reg <= go_i ? len_i : (left_reg != 8'h00 ? left_reg - 8'h01 : 8'h00);
         rx_valid_o <= (left_reg == 8'h01);
         // index is only meaningful with the pulse; otherwise it toggles
         rx_idx_o <= (left_reg == 8'h01) ? idx_i : ~rx_idx_o;
      end
   end
   assign bus_active_o = (left_reg != 8'h00);
   // ----------------------------------------------------------------
   // pending transmissions; aborting every buffer takes a while
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_pending_o <= 1'b0;
         drop_reg <= 8'h00;
      end else begin
         drop_reg <= (abort_i && tx_pending_o) ? drop_reg + 8'h01 : 8'h00;
         if (pend_i) begin
            tx_pending_o <= 1'b1;
         end else if (drop_reg == 8'(ABORT_LAT)) begin
            tx_pending_o <= 1'b0;
         end
      end
   end
endmodule

//--- sim/testbench.sv
// self-checking bench for the can module mode control block
`timescale 1ns/1ps
`include "cmmc_consts.svh"
module testbench;
   logic clk, rst, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
   logic awready, wready, arready, go, pend, bus_act, tx_pend, rx_valid, tx_abort, core_en, ce;
   logic [3:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic [7:0] len;
   logic [1:0] idx, rx_idx, ts_idx;
   logic [15:0] ts_data, timer, t0, stamp_exp;
   logic [2:0] mode, codes [6];
   int bad_count, n_compared, i, k;
   cmmc_top cmmc_top_i (.clock_i(clk), .sys_rst_i(rst), .ce_i(ce),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .bus_active_i(bus_act),
      .tx_pending_i(tx_pend), .rx_valid_i(rx_valid), .rx_buf_idx_i(rx_idx),
      .ts_rd_idx_i(ts_idx), .ts_rd_data_o(ts_data), .timer_o(timer),
      .tx_abort_o(tx_abort), .core_enable_o(core_en), .mode_o(mode));
   cmmc_can_peer cmmc_can_peer_i (.clock_i(clk), .sys_rst_i(rst), .go_i(go), .len_i(len),
      .pend_i(pend), .abort_i(tx_abort), .idx_i(idx), .bus_active_o(bus_act),
      .tx_pending_o(tx_pend), .rx_valid_o(rx_valid), .rx_idx_o(rx_idx));
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // timer value at the edge where a message lands
   always @(posedge clk) begin
      if (rx_valid === 1'b1) begin
         stamp_exp <= timer;
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic hang;
      check("wait bound", 32'h0, 32'h1);
      wrap_up();
   endtask
   // write address and data offered together, each dropped when taken
   task automatic axi_write(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awvalid && awready === 1'b1) begin
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            return;
         end
      end
      hang();
   endtask
   task automatic axi_read(input logic [3:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arvalid && arready === 1'b1) begin
            arvalid <= 1'b0;
         end
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            return;
         end
      end
      hang();
   endtask
   task automatic rd_chk(input string what, input logic [31:0] mask, input logic [31:0] exp);
      axi_read(`CMMC_CTRL_OFS);
      check(what, d & mask, exp);
   endtask
   // mode changes are not instant, so poll the status output under a bound
   task automatic wait_mode(input logic [2:0] want);
      for (k = 0; k < 60 && mode !== want; k++) begin
         @(posedge clk);
      end
      if (mode !== want) begin
         hang();
      end
   endtask
   task automatic frame(input logic [7:0] n, input logic [1:0] at);
      len <= n;
      idx <= at;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, go, pend} = '0;
      {awaddr, araddr, wdata, len, idx, ts_idx} = '0;
      codes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
      bad_count = 0;
      n_compared = 0;
      ce = 1'b1;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // bits 31:28 never read as one, so only the two mode fields show
      rd_chk("reset ctrl", 32'hffffffff, 32'h04800000);
      check("reset core", {31'h0, core_en}, 32'h0);
      axi_read(4'h4);
      check("unmapped rresp", {d[31:2] != 30'h0, r}, {1'b0, `CMMC_RESP_SLVERR});
      axi_write(4'h8, 32'hffffffff);
      check("unmapped bresp", {30'h0, r}, {30'h0, `CMMC_RESP_SLVERR});
      rd_chk("ignored write", 32'hffffffff, 32'h04800000);
      $display("test reset_map done");
      axi_write(`CMMC_CTRL_OFS, 32'hffffffff);
      wait_mode(3'h7);
      rd_chk("all ones", 32'hffffffff, 32'h07f0a81f);
      // mode code goes to bits 26:24, so the low part must be a full 24 bits
      for (i = 0; i < 6; i++) begin
         axi_write(`CMMC_CTRL_OFS, {5'h0, codes[i], 24'h00_8000});
         wait_mode(codes[i]);
         rd_chk("mode field", 32'h00e00000, {8'h0, codes[i], 21'h0});
      end
      for (i = 5; i < 7; i++) begin
         axi_write(`CMMC_CTRL_OFS, {5'h0, 3'(i), 24'h00_8000});
         repeat (6) @(posedge clk);
         check("reserved mode", {29'h0, mode}, 32'h7);
      end
      frame(8'd20, 2'h0);
      axi_write(`CMMC_CTRL_OFS, 32'h00008000);
      check("mode in frame", {29'h0, mode}, 32'h7);
      wait_mode(3'h0);
      check("mode after frame", {30'h0, bus_act, mode == 3'h0}, 32'h1);
      $display("test modes done");
      t0 = timer;
      frame(8'd3, 2'h3);
      repeat (8) @(posedge clk);
      check("timer off", {16'h0, timer}, {16'h0, t0});
      ts_idx <= 2'h3;
      repeat (2) @(posedge clk);
      check("stamp off", {16'h0, ts_data}, 32'h0);
      axi_write(`CMMC_CTRL_OFS, 32'h00108000);
      t0 = timer;
      repeat (8) @(posedge clk);
      check("timer on", {16'h0, timer}, {16'h0, t0 + 16'h8});
      frame(8'd4, 2'h2);
      repeat (8) @(posedge clk);
      ts_idx <= 2'h2;
      repeat (2) @(posedge clk);
      check("stamp on", {16'h0, ts_data}, {16'h0, stamp_exp});
      // a low enable must freeze the running timer and drop the readies
      ce <= 1'b0;
      @(posedge clk);
      t0 = timer;
      repeat (5) @(posedge clk);
      check("enable freeze", {15'h0, arready, timer}, {16'h0, t0});
      ce <= 1'b1;
      $display("test stamps done");
      pend <= 1'b1;
      @(posedge clk);
      pend <= 1'b0;
      axi_write(`CMMC_CTRL_OFS, 32'h08008000);
      check("abort out", {31'h0, tx_abort}, 32'h1);
      rd_chk("abort held", 32'h08000000, 32'h08000000);
      for (k = 0; k < 60 && tx_abort !== 1'b0; k++) begin
         @(posedge clk);
      end
      if (tx_abort !== 1'b0) begin
         hang();
      end
      check("abort done", {30'h0, tx_pend, tx_abort}, 32'h0);
      rd_chk("abort clear", 32'h08000000, 32'h0);
      $display("test abort done");
      frame(8'd30, 2'h1);
      axi_write(`CMMC_CTRL_OFS, 32'h00100000);
      check("drain core", {31'h0, core_en}, 32'h1);
      rd_chk("busy drain", 32'h00000800, 32'h00000800);
      for (i = 0; i < 30 && d[`CMMC_BUSY_BIT] !== 1'b0; i++) begin
         axi_read(`CMMC_CTRL_OFS);
      end
      if (d[`CMMC_BUSY_BIT] !== 1'b0) begin
         hang();
      end
      check("off state", {30'h0, bus_act, core_en}, 32'h0);
      t0 = timer;
      repeat (5) @(posedge clk);
      check("timer idle", {16'h0, timer}, {16'h0, t0});
      $display("test disable done");
      // reset again in mid-run: every field must fall back to its start value
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk("second reset", 32'hffffffff, 32'h04800000);
      check("second reset state", {15'h0, core_en, timer}, 32'h0);
      $display("test second_reset done");
      wrap_up();
   end
endmodule
